/* File: design/sar_adc_converter.sv */
`timescale 1ns/1ps
module sar_adc_converter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic dac_above_input_i,
    output logic [7:0] trial_code_o,
    sar_adc_if.converter link
);
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_TRIAL = 3'b010,
        ST_DONE = 3'b100
    } conv_state_t;

    conv_state_t state_reg, state_next;
    logic [7:0] approx_register_reg, approx_register_next;
    logic [7:0] trial_mask_reg, trial_mask_next;
    logic pending_reg, pending_next;
    logic start_meta_reg, start_sync_reg;

    // Two flops; the first feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_meta_reg <= 1'b0;
            start_sync_reg <= 1'b0;
        end else if (clk_en_i) begin
            start_meta_reg <= link.conv_start_n;
            start_sync_reg <= start_meta_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        approx_register_next = approx_register_reg;
        trial_mask_next = trial_mask_reg;
        pending_next = pending_reg;
        if (!start_sync_reg) begin
            // Any start pulse aborts and reloads
            state_next = ST_RESET;
            approx_register_next = sar_adc_pkg::RESET_CODE;
            trial_mask_next = sar_adc_pkg::MSB_MASK;
            pending_next = 1'b1;
        end else begin
            unique case (state_reg)
                ST_RESET: begin
                    state_next = ST_TRIAL;
                end
                ST_TRIAL: begin
                    // Decide current bit, raise next one
                    if (dac_above_input_i) begin
                        approx_register_next =
                            approx_register_reg & ~trial_mask_reg;
                    end
                    approx_register_next =
                        approx_register_next | (trial_mask_reg >> 1);
                    trial_mask_next = trial_mask_reg >> 1;
                    if (trial_mask_reg[0]) begin
                        state_next = ST_DONE;
                        pending_next = 1'b0;
                    end
                end
                ST_DONE: begin
                    state_next = ST_DONE;
                end
            endcase
        end
    end

    // First trial decided on the second edge after synced release; the
    // sync delay stands in for the setup slip the part allows
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_RESET;
            approx_register_reg <= sar_adc_pkg::RESET_CODE;
            trial_mask_reg <= sar_adc_pkg::MSB_MASK;
            pending_reg <= 1'b1;
        end else if (clk_en_i) begin
            state_reg <= state_next;
            approx_register_reg <= approx_register_next;
            trial_mask_reg <= trial_mask_next;
            pending_reg <= pending_next;
        end
    end

    // Upper bits settle as trials pass, usable for short cycles
    assign link.result_bits_o = approx_register_reg;
    assign link.result_bits_oe =
        {sar_adc_pkg::DATA_W{~link.out_enable_n}};
    assign link.result_pending = pending_reg;
    assign trial_code_o = approx_register_reg;
endmodule : sar_adc_converter

/* File: design/sar_adc_host.sv */
`timescale 1ns/1ps
module sar_adc_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic convert_req_i,
    input wire logic read_enable_i,
    input wire logic [3:0] short_bits_i,
    output logic busy_o,
    output logic result_valid_o,
    output logic [7:0] result_o,
    sar_adc_if.host link
);
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_START = 4'b0010,
        H_WAIT = 4'b0100,
        H_SETTLE = 4'b1000
    } host_state_t;

    host_state_t state_reg, state_next;
    logic [7:0] count_reg, count_next;
    logic [7:0] result_reg, result_next;
    logic valid_reg, valid_next;
    logic [3:0] bits_reg, bits_next;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        result_next = result_reg;
        valid_next = 1'b0;
        bits_next = bits_reg;
        unique case (state_reg)
            H_IDLE: begin
                if (convert_req_i) begin
                    state_next = H_START;
                    count_next = 8'h00;
                    bits_next = short_bits_i;
                end
            end
            H_START: begin
                count_next = count_reg + 8'h01;
                if (count_reg ==
                    8'(sar_adc_pkg::START_LOW_CYC - 1)) begin
                    state_next = H_WAIT;
                    count_next = 8'h00;
                end
            end
            H_WAIT: begin
                count_next = count_reg + 8'h01;
                if (!link.result_pending) begin
                    state_next = H_SETTLE;
                    count_next = 8'h00;
                end else if (bits_reg != 4'h0 &&
                    count_reg == 8'({4'h0, bits_reg} +
                        8'(sar_adc_pkg::SHORT_LAG_CYC))) begin
                    // Short cycle: keep only the settled top bits, since
                    // the next trial bit is already raised below them
                    result_next = link.result_bits_o &
                        ~(8'hff >> bits_reg);
                    valid_next = 1'b1;
                    state_next = H_IDLE;
                end else if (count_reg ==
                    8'(sar_adc_pkg::RESTART_WAIT_CYC)) begin
                    state_next = H_START;
                    count_next = 8'h00;
                end
            end
            H_SETTLE: begin
                count_next = count_reg + 8'h01;
                if (count_reg ==
                    8'(sar_adc_pkg::LSB_VALID_CYC - 1)) begin
                    result_next = link.result_bits_o;
                    valid_next = 1'b1;
                    state_next = H_IDLE;
                end
            end
            default: begin
                state_next = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= H_IDLE;
            count_reg <= 8'h00;
            result_reg <= 8'h00;
            valid_reg <= 1'b0;
            bits_reg <= 4'h0;
        end else if (clk_en_i) begin
            state_reg <= state_next;
            count_reg <= count_next;
            result_reg <= result_next;
            valid_reg <= valid_next;
            bits_reg <= bits_next;
        end
    end

    // Release lands on a clock edge with no START_SETUP_CYC margin; the converter's sync flops absorb the slip
    assign link.conv_start_n = (state_reg != H_START);
    assign link.out_enable_n = ~read_enable_i;
    assign busy_o = (state_reg != H_IDLE);
    assign result_valid_o = valid_reg;
    assign result_o = result_reg;
endmodule : sar_adc_host

/* File: design/sar_adc_if.sv */
`timescale 1ns/1ps
interface sar_adc_if;
    logic conv_start_n;
    logic out_enable_n;
    logic result_pending;
    logic [7:0] result_bits_o;
    logic [7:0] result_bits_oe;
    modport converter (
        input conv_start_n,
        input out_enable_n,
        output result_pending,
        output result_bits_o,
        output result_bits_oe
    );
    modport host (
        output conv_start_n,
        output out_enable_n,
        input result_pending,
        input result_bits_o,
        input result_bits_oe
    );
endinterface : sar_adc_if

/* File: design/sar_adc_pkg.sv */
// Operation
// - Clear trial bit when DAC exceeds input
// - Hold finished code until next start
// - Pending high during sequence, low when done
// - Enabled outputs show evolving approximation register
// - Output enable high floats all data outputs
// - Start low: MSB one, rest zero, pending
// - One bit per rising edge, MSB first
// - Eighth edge decides LSB, drops pending
// - Top X bits settled early for short-cycle
// - Host releases start ahead of clock edge (host releases it on a clock edge; START_SETUP_CYC is never used)
// - Late start release may delay start
// - Host restarts when pending never falls
// - Host waits before sampling the LSB
// - Calibration uses continuous start pulses
// - Host holds start low long enough
// - Start during conversion aborts and resets
// - Bit zero LSB, bit seven MSB
package sar_adc_pkg;
    localparam int DATA_W = 8;
    localparam logic [7:0] RESET_CODE = 8'h80;
    localparam logic [7:0] MSB_MASK = 8'h80;
    localparam int CLK_PERIOD_NS = 4;
    localparam int START_LOW_NS = 400;
    localparam int START_SETUP_NS = 300;
    localparam int LSB_VALID_NS = 500;
    // Two sync flops plus the step out of reset precede the first trial
    localparam int SHORT_LAG_CYC = 3;
    localparam int RESTART_WAIT_CYC = 64;
    // Least times round up, none below one cycle
    localparam int START_LOW_CYC =
        (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_SETUP_CYC =
        (START_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LSB_VALID_CYC =
        (LSB_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : sar_adc_pkg

/* File: dv/sar_adc_sva.sv */
`timescale 1ns/1ps
module sar_adc_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic conv_start_n,
    input wire logic out_enable_n,
    input wire logic result_pending,
    input wire logic [7:0] result_bits_o,
    input wire logic [7:0] result_bits_oe
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [3:0] high_cnt;
    // Edges with start seen high; saturates so a long idle never wraps
    always_ff @(posedge clk_i) begin
        if (rst_i || !conv_start_n) begin
            high_cnt <= 4'h0;
        end else if (high_cnt != 4'hf) begin
            high_cnt <= high_cnt + 4'h1;
        end
    end
    // Start held high long enough for all eight decisions
    sequence s_go;
        conv_start_n && high_cnt == 4'hb;
    endsequence
    sequence s_done;
        conv_start_n[*4] ##0 !result_pending[*2];
    endsequence
    property p_float;
        out_enable_n |-> result_bits_oe == 8'h00;
    endproperty
    a_float: assert property (p_float) else $error("bus not floated");
    property p_show;
        !out_enable_n |-> result_bits_oe == 8'hff;
    endproperty
    a_show: assert property (p_show) else $error("bus not driven");
    property p_reset;
        !conv_start_n[*5] |-> result_bits_o == 8'h80 && result_pending;
    endproperty
    a_reset: assert property (p_reset) else $error("no reset");
    property p_busy;
        $rose(conv_start_n) |-> ##2 result_pending[*8];
    endproperty
    a_busy: assert property (p_busy) else $error("early done");
    property p_done;
        s_go |-> ##[0:2] $fell(result_pending);
    endproperty
    a_done: assert property (p_done) else $error("done late");
    property p_first;
        $rose(conv_start_n) ##1 conv_start_n[*3]
            |-> ##[0:2] result_bits_o[6:0] == 7'h40;
    endproperty
    a_first: assert property (p_first) else $error("msb order");
    property p_hold;
        s_done |=> $stable(result_bits_o);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved");
    // Start is seen only after the synchroniser, never on the same edge
    property p_sync;
        $fell(conv_start_n) && !result_pending
            |=> $stable(result_bits_o) && !result_pending;
    endproperty
    a_sync: assert property (p_sync) else $error("unsynced start");
endmodule : sar_adc_sva

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 0;
    logic rst_i = 1;
    logic req = 0;
    logic rd = 0;
    logic [3:0] x = 0;
    logic busy, valid;
    logic [7:0] res, trial;
    logic [7:0] tgt = 0;
    logic [7:0] corner [4] = '{8'h00, 8'hff, 8'h80, 8'h7f};
    int fails = 0;
    bit hung = 1'b0;
    int checks = 0;
    int seed = 19392;
    sar_adc_if link ();
    always #2 clk_i = ~clk_i;
    // Comparator: DAC above input when the trial code exceeds the target
    sar_adc_converter i_sar_adc_converter (.clk_i(clk_i), .rst_i(rst_i),
        .clk_en_i(1'b1), .dac_above_input_i(trial > tgt),
        .trial_code_o(trial), .link(link));
    sar_adc_host i_sar_adc_host (.clk_i(clk_i), .rst_i(rst_i),
        .clk_en_i(1'b1), .convert_req_i(req), .read_enable_i(rd),
        .short_bits_i(x), .busy_o(busy), .result_valid_o(valid),
        .result_o(res), .link(link));
    sar_adc_sva i_sar_adc_sva (.clk_i(clk_i), .rst_i(rst_i),
        .conv_start_n(link.conv_start_n), .out_enable_n(link.out_enable_n),
        .result_pending(link.result_pending),
        .result_bits_o(link.result_bits_o),
        .result_bits_oe(link.result_bits_oe));
    function automatic logic [7:0] top_mask(logic [3:0] n);
        return (n == 4'h0) ? 8'hff : 8'hff << (4'h8 - n);
    endfunction : top_mask
    function automatic logic [7:0] exp_code(logic [7:0] t, logic [3:0] n);
        return t & top_mask(n);
    endfunction : exp_code
    task automatic cmp(logic [7:0] got, logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : cmp
    task automatic stop_test;
        $display("fails %0d checks %0d", fails, checks);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic conv(logic [7:0] t, logic [3:0] n, logic r);
        int k;
        logic [7:0] e;
        k = 0;
        e = exp_code(t, n);
        if (hung) return;
        tgt = t;
        x = n;
        rd = r;
        req = 1;
        while (busy !== 1'b1 && k < 50) begin
            tick(1);
            k++;
        end
        req = 0;
        while (valid !== 1'b1 && k < 2000) begin
            tick(1);
            k++;
        end
        if (k >= 2000) begin
            fails++;
            hung = 1'b1;
            $display("wrong value at %0t: no result", $time);
        end else begin
            cmp(res, e);
            cmp(link.result_bits_oe, {8{r}});
            cmp(link.result_bits_o & top_mask(n), e);
            tick(1);
        end
    endtask : conv
    initial begin
        tick(12);
        rst_i = 0;
        foreach (corner[i]) conv(corner[i], 4'h0, 1'b1);
        repeat (16) begin
            conv(8'($random(seed)), 4'h0, 1'($random(seed)));
        end
        for (int n = 1; n < 8; n++) begin
            conv(8'($random(seed)), n[3:0], 1'($random(seed)));
        end
        conv(8'h55, 4'h0, 1'b1);
        stop_test();
    end
endmodule : tb_top
